/* File: hdl/pecs_pkg.sv */
// Package for the two-counter event select block.
// Assumes a single 40 MHz core clock; event inputs are synchronous to it.
package pecs_pkg;
    // Register byte offsets
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_LOWER_CNT = 8'h04;
    localparam logic [7:0]  ADDR_UPPER_CNT = 8'h08;
    localparam logic [7:0]  ADDR_STATUS    = 8'h0c;
    // Control field layout
    localparam int          SEL_LO_POS     = 0;
    localparam int          SEL_HI_POS     = 8;
    localparam int          PT_EN_POS      = 16;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
    localparam logic [31:0] CNT_RESET      = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;
    // Block load/store reference weight
    localparam logic [3:0]  BLOCK_REFS     = 4'h8;
    // Select codes
    localparam logic [5:0] SEL_0D = 6'h0d;
    localparam logic [5:0] SEL_0E = 6'h0e;
    localparam logic [5:0] SEL_0F = 6'h0f;
    localparam logic [5:0] SEL_11 = 6'h11;
    localparam logic [5:0] SEL_12 = 6'h12;
    localparam logic [5:0] SEL_13 = 6'h13;
    localparam logic [5:0] SEL_14 = 6'h14;
    localparam logic [5:0] SEL_18 = 6'h18;
    localparam logic [5:0] SEL_1C = 6'h1c;
    localparam logic [5:0] SEL_20 = 6'h20;
    localparam logic [5:0] SEL_21 = 6'h21;
    localparam logic [5:0] SEL_22 = 6'h22;
    localparam logic [5:0] SEL_23 = 6'h23;
    localparam logic [5:0] SEL_24 = 6'h24;
    localparam logic [5:0] SEL_25 = 6'h25;
    localparam logic [5:0] SEL_27 = 6'h27;
    localparam logic [5:0] SEL_RSV_FIRST = 6'h2a;
    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] HSIZE_WORD    = 3'b010;

    // Single-cycle event strobes from internal sources
    typedef struct packed {
        logic l2_excl_hit_read_own;
        logic l2_dirty_writeback;
        logic l2_snoop_invalidate;
        logic l2_snoop_copyback;
        logic l2_data_read_miss;
        logic l2_data_block;
        logic l2_instr_read_miss;
        logic mem_read_issued;
        logic mem_write_issued;
        logic mem_read_returned;
        logic mem_seq_busy_stall;
        logic mem_buffer_overflow_stall;
        logic mem_speculative_accept;
        logic mem_bank_open_count;
        logic mem_seq_reads;
        logic mem_seq_writes;
        logic mem_page_conflict;
        logic snoop_rx;
        logic snoop_owned;
        logic marker_instr;
        logic fp_add_pipe_done;
        logic fp_mul_pipe_done;
    } pecs_events_t;

    typedef struct packed {
        logic [5:0] lower_event_select;
        logic [5:0] upper_event_select;
        logic       page_track_en;
    } pecs_ctrl_t;
endpackage : pecs_pkg

/* File: hdl/pecs_top.sv */
// Two event counters, each steered by its own six-bit select, on AHB-Lite.
// Assumes event strobes come from logic on i_ref_clk; the flow-control and
// snoop acknowledge levels are pins and get synchronised here.
//
// Notes on behaviour
// R01 - Lower 0x0d counts exclusive hits issuing read-own
// R02 - Upper 0x0d counts dirty subblock writebacks
// R03 - Lower 0x0e counts snoop invalidations
// R04 - Upper 0x0e counts snoop copybacks
// R05 - Lower 0x0f counts data read misses
// R06 - Upper 0x0f counts instruction read misses
// R07 - Lower 0x20/0x21 count issued reads, writes
// R08 - Lower 0x22 counts reads returned to bus
// R09 - Lower 0x23/0x24 count sequencer, buffer stalls
// R10 - Lower 0x25 counts speculative accepts
// R11 - Upper 0x20 counts bank open commands
// R12 - Upper 0x21/0x22 count sequencer reads, writes
// R13 - Upper 0x23 page conflicts, zero untracked
// R14 - Lower 0x11 counts received snoops
// R15 - Lower 0x12 counts system clock ticks with flow control asserted
// R16 - Lower 0x13 counts owned snoop acknowledges
// R17 - Lower 0x14, upper 0x1c count marker
// R18 - Lower 0x18 add, upper 0x27 multiply completions
// R19 - Codes 0x2a upward select nothing
// R20 - Stall events count every true cycle
// R21 - Cache events count every access
// R22 - Block access counts eight references
// R23 - Each counter follows its own select
// R24 - Reserved select never increments
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/10ps
module pecs_top (
    // Clock and reset
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_sys_rst,
    // AHB-Lite slave
    input  wire logic                 i_hsel,
    input  wire logic [7:0]           i_haddr,
    input  wire logic [1:0]           i_htrans,
    input  wire logic                 i_hwrite,
    input  wire logic [2:0]           i_hsize,
    input  wire logic [31:0]          i_hwdata,
    input  wire logic                 i_hready,
    output logic      [31:0]          o_hrdata,
    output logic                      o_hreadyout,
    output logic                      o_hresp,
    // Event sources
    input  wire pecs_pkg::pecs_events_t i_events,
    input  wire logic                 i_data_addr_flow_control,
    input  wire logic                 i_snoop_ack_pin,
    input  wire logic                 i_sys_clk_tick
);
    default clocking core_cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);

    // Synchronisers for pin levels
    logic [1:0] fc_sync;
    logic [1:0] ack_sync;
    logic [1:0] next_fc_sync;
    logic [1:0] next_ack_sync;

    always_comb begin
        next_fc_sync  = {fc_sync[0], i_data_addr_flow_control};
        next_ack_sync = {ack_sync[0], i_snoop_ack_pin};
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fc_sync  <= 2'h0;
            ack_sync <= 2'h0;
        end else begin
            fc_sync  <= next_fc_sync;
            ack_sync <= next_ack_sync;
        end
    end

    // Snoop acknowledge signals owned on a request strobe
    logic owned_hit;
    logic flow_hit;
    assign owned_hit = i_events.snoop_owned & ack_sync[1];      // R16
    assign flow_hit  = i_sys_clk_tick & fc_sync[1];             // R15

    // Register state
    pecs_pkg::pecs_ctrl_t ctrl;
    pecs_pkg::pecs_ctrl_t next_ctrl;
    logic [31:0] lower_event_counter;
    logic [31:0] upper_event_counter;
    logic [31:0] next_lower;
    logic [31:0] next_upper;
    logic        dph_write;
    logic        dph_read;
    logic [7:0]  dph_addr;
    logic        next_dph_write;
    logic        next_dph_read;
    logic [7:0]  next_dph_addr;
    logic [31:0] next_hrdata;

    // Lower counter increment mux
    function automatic logic [3:0] lower_inc(input logic [5:0] sel,
                                             input pecs_pkg::pecs_events_t ev,
                                             input logic fl, input logic ow);
        logic [3:0] inc;
        inc = 4'h0;
        if (sel < pecs_pkg::SEL_RSV_FIRST) begin                // R19 R24
            unique case (sel)
                pecs_pkg::SEL_0D: inc = {3'h0, ev.l2_excl_hit_read_own};  // R01 R21
                pecs_pkg::SEL_0E: inc = {3'h0, ev.l2_snoop_invalidate};   // R03
                pecs_pkg::SEL_0F: begin
                    if (ev.l2_data_block) begin
                        inc = pecs_pkg::BLOCK_REFS;                        // R22
                    end else begin
                        inc = {3'h0, ev.l2_data_read_miss};                // R05
                    end
                end
                pecs_pkg::SEL_11: inc = {3'h0, ev.snoop_rx};               // R14
                pecs_pkg::SEL_12: inc = {3'h0, fl};                        // R15
                pecs_pkg::SEL_13: inc = {3'h0, ow};                        // R16
                pecs_pkg::SEL_14: inc = {3'h0, ev.marker_instr};           // R17
                pecs_pkg::SEL_18: inc = {3'h0, ev.fp_add_pipe_done};       // R18
                pecs_pkg::SEL_20: inc = {3'h0, ev.mem_read_issued};        // R07
                pecs_pkg::SEL_21: inc = {3'h0, ev.mem_write_issued};       // R07
                pecs_pkg::SEL_22: inc = {3'h0, ev.mem_read_returned};      // R08
                pecs_pkg::SEL_23: inc = {3'h0, ev.mem_seq_busy_stall};     // R09 R20
                pecs_pkg::SEL_24: inc = {3'h0, ev.mem_buffer_overflow_stall}; // R09 R20
                pecs_pkg::SEL_25: inc = {3'h0, ev.mem_speculative_accept}; // R10
                default:          inc = 4'h0;
            endcase
        end
        return inc;
    endfunction : lower_inc

    // Upper counter increment mux
    function automatic logic [3:0] upper_inc(input logic [5:0] sel,
                                             input pecs_pkg::pecs_events_t ev,
                                             input logic pt);
        logic [3:0] inc;
        inc = 4'h0;
        if (sel < pecs_pkg::SEL_RSV_FIRST) begin                // R19 R24
            unique case (sel)
                pecs_pkg::SEL_0D: inc = {3'h0, ev.l2_dirty_writeback};   // R02
                pecs_pkg::SEL_0E: inc = {3'h0, ev.l2_snoop_copyback};    // R04
                pecs_pkg::SEL_0F: inc = {3'h0, ev.l2_instr_read_miss};   // R06 R21
                pecs_pkg::SEL_1C: inc = {3'h0, ev.marker_instr};         // R17
                pecs_pkg::SEL_20: inc = {3'h0, ev.mem_bank_open_count};  // R11
                pecs_pkg::SEL_21: inc = {3'h0, ev.mem_seq_reads};        // R12
                pecs_pkg::SEL_22: inc = {3'h0, ev.mem_seq_writes};       // R12
                pecs_pkg::SEL_23: inc = {3'h0, ev.mem_page_conflict & pt}; // R13
                pecs_pkg::SEL_27: inc = {3'h0, ev.fp_mul_pipe_done};     // R18
                default:          inc = 4'h0;
            endcase
        end
        return inc;
    endfunction : upper_inc

    logic [3:0] lo_step;
    logic [3:0] up_step;
    logic       wr_ctrl;
    logic       wr_lo;
    logic       wr_up;

    always_comb begin
        lo_step = lower_inc(ctrl.lower_event_select, i_events, flow_hit, owned_hit); // R23
        up_step = upper_inc(ctrl.upper_event_select, i_events, ctrl.page_track_en);  // R23
        wr_ctrl = dph_write && (dph_addr == pecs_pkg::ADDR_CTRL);
        wr_lo   = dph_write && (dph_addr == pecs_pkg::ADDR_LOWER_CNT);
        wr_up   = dph_write && (dph_addr == pecs_pkg::ADDR_UPPER_CNT);
        next_ctrl = ctrl;
        if (wr_ctrl) begin
            next_ctrl.lower_event_select = i_hwdata[pecs_pkg::SEL_LO_POS +: 6];
            next_ctrl.upper_event_select = i_hwdata[pecs_pkg::SEL_HI_POS +: 6];
            next_ctrl.page_track_en      = i_hwdata[pecs_pkg::PT_EN_POS];
        end
        // A software write to a counter wins over a same-cycle event
        next_lower = wr_lo ? i_hwdata : lower_event_counter + {28'h0, lo_step};
        next_upper = wr_up ? i_hwdata : upper_event_counter + {28'h0, up_step};
    end

    // AHB-Lite: zero wait states, always OKAY
    logic addr_ok;
    always_comb begin
        addr_ok = i_hsel && i_hready && (i_htrans == pecs_pkg::HTRANS_NONSEQ)
                  && (i_hsize == pecs_pkg::HSIZE_WORD);
        next_dph_write = addr_ok && i_hwrite;
        next_dph_read  = addr_ok && !i_hwrite;
        next_dph_addr  = addr_ok ? i_haddr : dph_addr;
        next_hrdata    = pecs_pkg::ZERO_WORD;
        if (addr_ok && !i_hwrite) begin
            unique case (i_haddr)
                pecs_pkg::ADDR_CTRL: begin
                    next_hrdata = pecs_pkg::ZERO_WORD;
                    next_hrdata[pecs_pkg::SEL_LO_POS +: 6] = ctrl.lower_event_select;
                    next_hrdata[pecs_pkg::SEL_HI_POS +: 6] = ctrl.upper_event_select;
                    next_hrdata[pecs_pkg::PT_EN_POS]       = ctrl.page_track_en;
                end
                pecs_pkg::ADDR_LOWER_CNT: next_hrdata = next_lower;
                pecs_pkg::ADDR_UPPER_CNT: next_hrdata = next_upper;
                pecs_pkg::ADDR_STATUS: begin
                    next_hrdata = {26'h0, ack_sync[1], fc_sync[1],
                                   lo_step != 4'h0, up_step != 4'h0,
                                   ctrl.lower_event_select >= pecs_pkg::SEL_RSV_FIRST,
                                   ctrl.upper_event_select >= pecs_pkg::SEL_RSV_FIRST};
                end
                default: next_hrdata = pecs_pkg::ZERO_WORD;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl                <= pecs_pkg::pecs_ctrl_t'(pecs_pkg::CTRL_RESET[12:0]);
            lower_event_counter <= pecs_pkg::CNT_RESET;
            upper_event_counter <= pecs_pkg::CNT_RESET;
            dph_write           <= 1'b0;
            dph_read            <= 1'b0;
            dph_addr            <= 8'h00;
            o_hrdata            <= pecs_pkg::ZERO_WORD;
        end else begin
            ctrl                <= next_ctrl;
            lower_event_counter <= next_lower;
            upper_event_counter <= next_upper;
            dph_write           <= next_dph_write;
            dph_read            <= next_dph_read;
            dph_addr            <= next_dph_addr;
            o_hrdata            <= next_hrdata;
        end
    end

    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;

    // Assertions
    property p_reserved_lo;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (ctrl.lower_event_select >= pecs_pkg::SEL_RSV_FIRST) && !wr_lo
        |=> lower_event_counter == $past(lower_event_counter);
    endproperty
    a_reserved_lo: assert property (p_reserved_lo) else $error("reserved lower counted"); // R24

    property p_reserved_up;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (ctrl.upper_event_select >= pecs_pkg::SEL_RSV_FIRST) && !wr_up
        |=> $stable(upper_event_counter);
    endproperty
    a_reserved_up: assert property (p_reserved_up) else $error("reserved upper counted"); // R19

    property p_marker_both;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (ctrl.lower_event_select == pecs_pkg::SEL_14) &&
        (ctrl.upper_event_select == pecs_pkg::SEL_1C) && !wr_lo && !wr_up
        |=> (lower_event_counter - $past(lower_event_counter)) ==
            (upper_event_counter - $past(upper_event_counter));
    endproperty
    a_marker_both: assert property (p_marker_both) else $error("marker counts differ"); // R17

    property p_page_off;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        !ctrl.page_track_en && ctrl.upper_event_select == pecs_pkg::SEL_23 && !wr_up
        |=> $stable(upper_event_counter);
    endproperty
    a_page_off: assert property (p_page_off) else $error("page conflict without tracking"); // R13

    property p_block_eight;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        ctrl.lower_event_select == pecs_pkg::SEL_0F && i_events.l2_data_block && !wr_lo
        |=> lower_event_counter == $past(lower_event_counter) + 32'h8;
    endproperty
    a_block_eight: assert property (p_block_eight) else $error("block not eight"); // R22

    property p_stall_cycles;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        ctrl.lower_event_select == pecs_pkg::SEL_23 && !wr_lo && !wr_ctrl
        && i_events.mem_seq_busy_stall [*2]
        |=> lower_event_counter == $past(lower_event_counter, 2) + 32'h2;
    endproperty
    a_stall_cycles: assert property (p_stall_cycles) else $error("stall cycles missed"); // R20

    property p_owned;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        ctrl.lower_event_select == pecs_pkg::SEL_13 && !wr_lo
        |=> lower_event_counter == $past(lower_event_counter)
            + {31'h0, $past(i_events.snoop_owned && ack_sync[1])};
    endproperty
    a_owned: assert property (p_owned) else $error("owned count wrong"); // R16

    property p_fp_mul;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        ctrl.upper_event_select == pecs_pkg::SEL_27 && !wr_up
        |=> upper_event_counter == $past(upper_event_counter)
            + {31'h0, $past(i_events.fp_mul_pipe_done)};
    endproperty
    a_fp_mul: assert property (p_fp_mul) else $error("multiply completions wrong"); // R18

    property p_ahb_ready;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        o_hreadyout && !o_hresp;
    endproperty
    a_ahb_ready: assert property (p_ahb_ready) else $error("bus not ready");

    property p_lo_excl;
        ctrl.lower_event_select == pecs_pkg::SEL_0D && !wr_lo
        |=> lower_event_counter == $past(lower_event_counter)
            + {31'h0, $past(i_events.l2_excl_hit_read_own)};
    endproperty
    a_lo_excl: assert property (p_lo_excl) else $error("exclusive hit count wrong"); // R01

    property p_up_wb;
        ctrl.upper_event_select == pecs_pkg::SEL_0D && !wr_up
        |=> upper_event_counter == $past(upper_event_counter)
            + {31'h0, $past(i_events.l2_dirty_writeback)};
    endproperty
    a_up_wb: assert property (p_up_wb) else $error("writeback count wrong"); // R02

    property p_lo_inv;
        ctrl.lower_event_select == pecs_pkg::SEL_0E && !wr_lo
        |=> lower_event_counter == $past(lower_event_counter)
            + {31'h0, $past(i_events.l2_snoop_invalidate)};
    endproperty
    a_lo_inv: assert property (p_lo_inv) else $error("invalidate count wrong"); // R03

    property p_up_cb;
        ctrl.upper_event_select == pecs_pkg::SEL_0E && !wr_up
        |=> upper_event_counter == $past(upper_event_counter)
            + {31'h0, $past(i_events.l2_snoop_copyback)};
    endproperty
    a_up_cb: assert property (p_up_cb) else $error("copyback count wrong"); // R04

    property p_up_imiss;
        ctrl.upper_event_select == pecs_pkg::SEL_0F && !wr_up
        |=> upper_event_counter == $past(upper_event_counter)
            + {31'h0, $past(i_events.l2_instr_read_miss)};
    endproperty
    a_up_imiss: assert property (p_up_imiss) else $error("instr miss count wrong"); // R06

    property p_lo_rd;
        ctrl.lower_event_select == pecs_pkg::SEL_20 && !wr_lo
        |=> lower_event_counter == $past(lower_event_counter)
            + {31'h0, $past(i_events.mem_read_issued)};
    endproperty
    a_lo_rd: assert property (p_lo_rd) else $error("issued read count wrong"); // R07

    property p_up_bank;
        ctrl.upper_event_select == pecs_pkg::SEL_20 && !wr_up
        |=> upper_event_counter == $past(upper_event_counter)
            + {31'h0, $past(i_events.mem_bank_open_count)};
    endproperty
    a_up_bank: assert property (p_up_bank) else $error("bank open count wrong"); // R11

    property p_up_rd;
        ctrl.upper_event_select == pecs_pkg::SEL_21 && !wr_up
        |=> upper_event_counter == $past(upper_event_counter)
            + {31'h0, $past(i_events.mem_seq_reads)};
    endproperty
    a_up_rd: assert property (p_up_rd) else $error("sequencer read count wrong"); // R12

    property p_lo_snoop;
        ctrl.lower_event_select == pecs_pkg::SEL_11 && !wr_lo
        |=> lower_event_counter == $past(lower_event_counter)
            + {31'h0, $past(i_events.snoop_rx)};
    endproperty
    a_lo_snoop: assert property (p_lo_snoop) else $error("snoop count wrong"); // R14

    c_lo_count: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        lo_step != 4'h0 ##1 lo_step != 4'h0);
    c_up_count: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        up_step != 4'h0);
    c_block: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        lo_step == pecs_pkg::BLOCK_REFS);
    c_ctrl_write: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        wr_ctrl ##1 dph_read);
endmodule : pecs_top

/* File: test/pecs_event_src.sv */
// Event source model standing in for pipeline, cache and memory sources.
// Assumes the bench calls its tasks; outputs change just after a rising edge.
`timescale 1ns/10ps
module pecs_event_src (
    // Clock
    input  wire logic              i_clk,
    // Event outputs
    output pecs_pkg::pecs_events_t o_events,
    output logic                   o_flow,
    output logic                   o_ack,
    output logic                   o_tick
);
    initial begin
        o_events = '0;
        o_flow   = 1'b0;
        o_ack    = 1'b0;
        o_tick   = 1'b0;
    end

    task set_pins(input logic flow, input logic ack);
        @(posedge i_clk);
        o_flow <= flow;
        o_ack  <= ack;
        // Pins pass a two-stage synchroniser before they count
        repeat (3) @(posedge i_clk);
    endtask : set_pins

    // Holds the mask for n cycles, so levels count once per cycle
    task pulse(input logic [21:0] mask, input logic tick, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge i_clk);
            o_events <= pecs_pkg::pecs_events_t'(mask);
            o_tick   <= tick;
        end
        @(posedge i_clk);
        o_events <= '0;
        o_tick   <= 1'b0;
    endtask : pulse
endmodule : pecs_event_src

/* File: test/tb_pecs_top.sv */
// Self-checking bench for the two-counter event select block.
// Assumes the AHB-Lite slave answers with zero wait states and OKAY.
`timescale 1ns/10ps
module tb_pecs_top;
    typedef struct packed {
        logic [5:0]  lo;
        logic [5:0]  hi;
        logic        pt;
        logic        flow;
        logic        ack;
        logic        tick;
        logic [21:0] mask;
        logic [31:0] exp_lo;
        logic [31:0] exp_hi;
    } pecs_case_t;

    localparam pecs_case_t CASES [20] = '{
        '{6'h0d, 6'h0d, 1'b0, 1'b0, 1'b0, 1'b0, 22'h300000, 32'h3, 32'h3},
        '{6'h0e, 6'h0e, 1'b0, 1'b0, 1'b0, 1'b0, 22'h0c0000, 32'h3, 32'h3},
        '{6'h0f, 6'h0f, 1'b0, 1'b0, 1'b0, 1'b0, 22'h028000, 32'h3, 32'h3},
        '{6'h0f, 6'h0e, 1'b0, 1'b0, 1'b0, 1'b0, 22'h030000, 32'h18, 32'h0},
        '{6'h20, 6'h20, 1'b0, 1'b0, 1'b0, 1'b0, 22'h004100, 32'h3, 32'h3},
        '{6'h21, 6'h21, 1'b0, 1'b0, 1'b0, 1'b0, 22'h002080, 32'h3, 32'h3},
        '{6'h22, 6'h22, 1'b0, 1'b0, 1'b0, 1'b0, 22'h001040, 32'h3, 32'h3},
        '{6'h23, 6'h23, 1'b1, 1'b0, 1'b0, 1'b0, 22'h000820, 32'h3, 32'h3},
        '{6'h23, 6'h23, 1'b0, 1'b0, 1'b0, 1'b0, 22'h000020, 32'h0, 32'h0},
        '{6'h24, 6'h0d, 1'b0, 1'b0, 1'b0, 1'b0, 22'h000400, 32'h3, 32'h0},
        '{6'h25, 6'h0d, 1'b0, 1'b0, 1'b0, 1'b0, 22'h000200, 32'h3, 32'h0},
        '{6'h11, 6'h0d, 1'b0, 1'b0, 1'b0, 1'b0, 22'h000010, 32'h3, 32'h0},
        '{6'h12, 6'h0d, 1'b0, 1'b1, 1'b0, 1'b1, 22'h000000, 32'h3, 32'h0},
        '{6'h12, 6'h0d, 1'b0, 1'b0, 1'b0, 1'b1, 22'h000000, 32'h0, 32'h0},
        '{6'h13, 6'h0d, 1'b0, 1'b0, 1'b1, 1'b0, 22'h000008, 32'h3, 32'h0},
        '{6'h13, 6'h0d, 1'b0, 1'b0, 1'b0, 1'b0, 22'h000008, 32'h0, 32'h0},
        '{6'h14, 6'h1c, 1'b0, 1'b0, 1'b0, 1'b0, 22'h000004, 32'h3, 32'h3},
        '{6'h18, 6'h27, 1'b0, 1'b0, 1'b0, 1'b0, 22'h000003, 32'h3, 32'h3},
        '{6'h2a, 6'h3f, 1'b0, 1'b1, 1'b1, 1'b1, 22'h3fffff, 32'h0, 32'h0},
        '{6'h1c, 6'h14, 1'b0, 1'b0, 1'b0, 1'b0, 22'h3fffff, 32'h0, 32'h0}
    };

    logic                   i_ref_clk;
    logic                   i_sys_rst;
    logic                   hsel;
    logic [7:0]             haddr;
    logic [1:0]             htrans;
    logic                   hwrite;
    logic [2:0]             hsize;
    logic [31:0]            hwdata;
    logic [31:0]            hrdata;
    logic                   hreadyout;
    logic                   hresp;
    logic                   hready_mid;
    logic [31:0]            hrdata_mid;
    pecs_pkg::pecs_events_t events;
    logic                   flow;
    logic                   ack;
    logic                   tick;
    int                     err_count;
    int                     checked;

    pecs_top u_dut (
        .i_ref_clk                (i_ref_clk),
        .i_sys_rst                (i_sys_rst),
        .i_hsel                   (hsel),
        .i_haddr                  (haddr),
        .i_htrans                 (htrans),
        .i_hwrite                 (hwrite),
        .i_hsize                  (hsize),
        .i_hwdata                 (hwdata),
        .i_hready                 (hreadyout),
        .o_hrdata                 (hrdata),
        .o_hreadyout              (hreadyout),
        .o_hresp                  (hresp),
        .i_events                 (events),
        .i_data_addr_flow_control (flow),
        .i_snoop_ack_pin          (ack),
        .i_sys_clk_tick           (tick)
    );

    pecs_event_src u_src (
        .i_clk    (i_ref_clk),
        .o_events (events),
        .o_flow   (flow),
        .o_ack    (ack),
        .o_tick   (tick)
    );

    always #12.5 i_ref_clk = ~i_ref_clk;

    // Mid-cycle copies give the master a race-free view at the next edge
    always @(negedge i_ref_clk) begin
        hready_mid <= hreadyout;
        hrdata_mid <= hrdata;
    end

    task end_sim;
        $display("Checks %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task ahb_xfer(input logic [7:0] addr, input logic wr, input logic [31:0] wdata,
                  output logic [31:0] rdata);
        @(posedge i_ref_clk);
        hsel   <= 1'b1;
        haddr  <= addr;
        htrans <= pecs_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        hsize  <= pecs_pkg::HSIZE_WORD;
        do @(posedge i_ref_clk); while (hready_mid !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wdata;
        do @(posedge i_ref_clk); while (hready_mid !== 1'b1);
        rdata = hrdata_mid;
    endtask : ahb_xfer

    task wr(input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] dummy;
        ahb_xfer(addr, 1'b1, data, dummy);
    endtask : wr

    task rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] val;
        ahb_xfer(addr, 1'b0, 32'h0000_0000, val);
        check(val, exp);
        check({31'h0, hresp}, 32'h0000_0000);
    endtask : rd_chk

    initial begin
        i_ref_clk = 1'b0;
        i_sys_rst = 1'b1;
        hsel      = 1'b0;
        haddr     = 8'h00;
        htrans    = 2'b00;
        hwrite    = 1'b0;
        hsize     = 3'h0;
        hwdata    = 32'h0000_0000;
        err_count = 0;
        checked   = 0;
        repeat (6) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        rd_chk(pecs_pkg::ADDR_CTRL, pecs_pkg::CTRL_RESET);
        rd_chk(pecs_pkg::ADDR_LOWER_CNT, pecs_pkg::CNT_RESET);
        rd_chk(pecs_pkg::ADDR_UPPER_CNT, pecs_pkg::CNT_RESET);
        wr(8'h10, 32'hffff_ffff);
        rd_chk(8'h10, pecs_pkg::ZERO_WORD);
        wr(pecs_pkg::ADDR_CTRL, 32'h0001_3f2a);
        rd_chk(pecs_pkg::ADDR_CTRL, 32'h0001_3f2a);
        wr(pecs_pkg::ADDR_LOWER_CNT, 32'hdead_beef);
        rd_chk(pecs_pkg::ADDR_LOWER_CNT, 32'hdead_beef);
        foreach (CASES[i]) begin
            u_src.set_pins(CASES[i].flow, CASES[i].ack);
            wr(pecs_pkg::ADDR_CTRL, {15'h0000, CASES[i].pt, 2'h0, CASES[i].hi,
                                     2'h0, CASES[i].lo});
            wr(pecs_pkg::ADDR_LOWER_CNT, 32'h0000_0000);
            wr(pecs_pkg::ADDR_UPPER_CNT, 32'h0000_0000);
            u_src.pulse(CASES[i].mask, CASES[i].tick, 3);
            rd_chk(pecs_pkg::ADDR_LOWER_CNT, CASES[i].exp_lo);
            rd_chk(pecs_pkg::ADDR_UPPER_CNT, CASES[i].exp_hi);
        end
        wr(pecs_pkg::ADDR_CTRL, 32'h0000_2929);
        rd_chk(pecs_pkg::ADDR_STATUS, 32'h0000_0000);
        wr(pecs_pkg::ADDR_CTRL, 32'h0000_3f2a);
        rd_chk(pecs_pkg::ADDR_STATUS, 32'h0000_0003);
        wr(pecs_pkg::ADDR_STATUS, 32'hffff_ffff);
        rd_chk(pecs_pkg::ADDR_STATUS, 32'h0000_0003);
        wr(pecs_pkg::ADDR_LOWER_CNT, 32'h0000_0055);
        // Second reset mid-run
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        rd_chk(pecs_pkg::ADDR_CTRL, pecs_pkg::CTRL_RESET);
        rd_chk(pecs_pkg::ADDR_LOWER_CNT, pecs_pkg::CNT_RESET);
        end_sim();
    end

    // Whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_sim();
    end
endmodule : tb_pecs_top
